// [rtc_latch_irq.sv]
// Bus decode, time read latch, status, masks, alarm compare and interrupt drive
`timescale 1ns/1ps
// Notes on behaviour
// - Reading hundredths captures the seven other time counters into a latch.
// - Hundredths reads always return the live count, never a latched one.
// - Latched values hold and are returned until hundredths is read again.
// - Alarm RAM reads return stored bytes directly, with no latching.
// - Status flags mark every counter increment since last read, mask ignored.
// - Each status read clears all flags except those set by events in the same cycle, right after returning the data.
// - Top status bit set whenever an interrupt was generated since last read.
// - Alarm-caused interrupt also sets the lowest status bit.
// - A status read switches the interrupt output transistor off unless an interrupt event occurs in the same cycle.
// - Periodic interrupts need global enable and a mask bit one to six.
// - Periodic interrupt fires whenever a masked-in counter increments.
// - Following periodic interrupts come exactly one interval apart.
// - Alarm interrupts need global enable and mask bit zero.
// - Exact alarm match sets status bits zero and seven, turns output on.
// - Masked alarm fields other than hundredths are skipped and match any counter value.
// - Masked hundredths alarm field acts as if programmed to zero.
// - Backup supply below threshold blocks all bus reads and writes.
// - Writes at the status address load the interrupt mask instead.
// - Mask bit three selects the one-second periodic interrupt.
// - Command register at address eleven hex holds frequency, enable, run, test.
module rtc_latch_irq #(
    parameter int PERIODIC_COUNT = rtc_pkg::PERIODIC_COUNT,
    parameter int ALARM_WORDS = rtc_pkg::ALARM_WORDS
) (
    input wire logic clock,
    input wire logic resetn,
    input wire rtc_pkg::bus_pins_t bus_pins,
    input wire logic supply_valid_signal,
    input wire rtc_pkg::time_bank_t time_live,
    input wire logic [PERIODIC_COUNT-1:0] counter_increment,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic irq_drive,
    output rtc_pkg::counter_wr_t counter_wr,
    output logic [7:0] command_out
);
    // Elaboration check on the shape the logic serves
    if (PERIODIC_COUNT != 6 || ALARM_WORDS != 8) begin : g_shape_check
        $error("rtc_latch_irq supports six periodic intervals and eight alarm words");
    end

    // Bus group
    logic rd_active_reg, rd_active_next, wr_active_reg, wr_active_next;
    logic [7:0] data_reg, data_next;
    logic oe_reg, oe_next;
    logic [6:0] mask_reg, mask_next;
    logic [7:0] command_reg, command_next;
    rtc_pkg::counter_wr_t cwr_reg, cwr_next;
    // Latch group
    rtc_pkg::time_bank_t latch_reg, latch_next;
    // Status group
    logic [7:0] status_reg, status_next;
    logic irq_reg, irq_next;
    logic tick_seen_reg, tick_seen_next;

    logic rd_level, wr_level, rd_start, wr_start;
    logic rd_hund, rd_status, wr_alarm;
    logic alarm_hit, periodic_fire, alarm_fire, irq_event;
    logic [7:0] events;
    logic [ALARM_WORDS-1:0][7:0] alarm_words;

    // Field mask flag of an alarm byte
    function automatic logic field_masked(input logic [7:0] value);
        return value[rtc_pkg::BIT_ALARM_FIELD_MASK];
    endfunction

    // Address range test used by read and write decode
    function automatic logic in_range(input logic [4:0] a, input logic [4:0] lo,
                                      input logic [4:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    assign rd_level = supply_valid_signal && !bus_pins.chip_sel_n && !bus_pins.read_n;
    assign wr_level = supply_valid_signal && !bus_pins.chip_sel_n && !bus_pins.write_n;
    assign rd_start = rd_level && !rd_active_reg;
    assign wr_start = wr_level && !wr_active_reg;
    assign rd_hund = rd_start && bus_pins.addr == rtc_pkg::ADDR_HUND;
    assign rd_status = rd_start && bus_pins.addr == rtc_pkg::ADDR_STATUS;
    assign wr_alarm = wr_start && in_range(bus_pins.addr, rtc_pkg::ADDR_ALARM_FIRST,
                                           rtc_pkg::ADDR_ALARM_LAST);

    alarm_store #(
        .WORDS(ALARM_WORDS),
        .WIDTH(rtc_pkg::DATA_W)
    ) u_alarm (
        .clock(clock),
        .resetn(resetn),
        .wr_en(wr_alarm),
        .wr_addr(bus_pins.addr[2:0]),
        .wr_data(bus_pins.wdata),
        .rd_addr(bus_pins.addr[2:0]),
        .rd_data(),
        .contents(alarm_words)
    );

    // Bus decode: read data, mask, command and counter writes
    always_comb begin
        rd_active_next = rd_level;
        wr_active_next = wr_level;
        oe_next = rd_level;
        data_next = data_reg;
        mask_next = mask_reg;
        command_next = command_reg;
        cwr_next = '0;
        if (rd_start) begin
            if (bus_pins.addr == rtc_pkg::ADDR_HUND) begin
                data_next = time_live[0];
            end else if (in_range(bus_pins.addr, 5'h01, rtc_pkg::ADDR_TIME_LAST)) begin
                data_next = latch_reg[bus_pins.addr[2:0]];
            end else if (in_range(bus_pins.addr, rtc_pkg::ADDR_ALARM_FIRST,
                                  rtc_pkg::ADDR_ALARM_LAST)) begin
                data_next = alarm_words[bus_pins.addr[2:0]];
            end else if (bus_pins.addr == rtc_pkg::ADDR_STATUS) begin
                data_next = status_reg;
            end else if (bus_pins.addr == rtc_pkg::ADDR_COMMAND) begin
                data_next = command_reg;
            end else begin
                data_next = rtc_pkg::DATA_RESET;
            end
        end
        if (wr_start) begin
            if (in_range(bus_pins.addr, rtc_pkg::ADDR_HUND, rtc_pkg::ADDR_TIME_LAST)) begin
                cwr_next.en = 1'b1;
                cwr_next.index = bus_pins.addr[2:0];
                cwr_next.data = bus_pins.wdata;
            end else if (bus_pins.addr == rtc_pkg::ADDR_STATUS) begin
                mask_next = bus_pins.wdata[6:0];
            end else if (bus_pins.addr == rtc_pkg::ADDR_COMMAND) begin
                command_next = bus_pins.wdata;
            end
        end
    end

    // Bus group registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rd_active_reg <= 1'b0;
            wr_active_reg <= 1'b0;
            oe_reg <= 1'b0;
            data_reg <= rtc_pkg::DATA_RESET;
            mask_reg <= rtc_pkg::MASK_RESET;
            command_reg <= rtc_pkg::COMMAND_RESET;
            cwr_reg <= '0;
        end else begin
            rd_active_reg <= rd_active_next;
            wr_active_reg <= wr_active_next;
            oe_reg <= oe_next;
            data_reg <= data_next;
            mask_reg <= mask_next;
            command_reg <= command_next;
            cwr_reg <= cwr_next;
        end
    end

    always_comb begin
        latch_next = latch_reg;
        if (rd_hund) begin
            latch_next = time_live;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    always_comb begin
        alarm_hit = tick_seen_reg;
        for (int i = 0; i < ALARM_WORDS; i++) begin
            if (!field_masked(alarm_words[i])) begin
                if (alarm_words[i][6:0] != time_live[i][6:0]) begin
                    alarm_hit = 1'b0;
                end
            end else if (i == 0 && time_live[0] != 8'h00) begin
                alarm_hit = 1'b0;
            end
        end
    end

    assign periodic_fire = command_reg[rtc_pkg::BIT_GLOBAL_EN]
        && |(mask_reg[rtc_pkg::BIT_PERIODIC_HI:rtc_pkg::BIT_PERIODIC_LO] & counter_increment);
    assign alarm_fire = alarm_hit && command_reg[rtc_pkg::BIT_GLOBAL_EN]
        && mask_reg[rtc_pkg::BIT_ALARM];
    assign irq_event = periodic_fire || alarm_fire;

    always_comb begin
        events = '0;
        events[rtc_pkg::BIT_PERIODIC_HI:rtc_pkg::BIT_PERIODIC_LO] = counter_increment;
        events[rtc_pkg::BIT_ALARM] = alarm_fire;
        events[rtc_pkg::BIT_ANY] = irq_event;
    end

    always_comb begin
        tick_seen_next = counter_increment[0];
        status_next = (rd_status ? rtc_pkg::STATUS_RESET : status_reg) | events;
        irq_next = (irq_reg && !rd_status) || irq_event;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            status_reg <= rtc_pkg::STATUS_RESET;
            irq_reg <= 1'b0;
            tick_seen_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg <= irq_next;
            tick_seen_reg <= tick_seen_next;
        end
    end

    assign data_out = data_reg;
    assign data_oe = oe_reg;
    assign irq_drive = irq_reg;
    assign counter_wr = cwr_reg;
    assign command_out = command_reg;

    latch_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        !$past(rd_hund) |-> $stable(latch_reg))
        else $error("time latch changed without a hundredths read");

    latch_capture_a: assert property (@(posedge clock) disable iff (!resetn)
        rd_hund |=> latch_reg == $past(time_live))
        else $error("time latch missed capture");

    hund_live_a: assert property (@(posedge clock) disable iff (!resetn)
        rd_hund |=> data_out == $past(time_live[0]) && data_oe)
        else $error("hundredths read did not return live count");

    status_clear_a: assert property (@(posedge clock) disable iff (!resetn)
        rd_status |=> status_reg == $past(events) && data_out == $past(status_reg))
        else $error("status read did not clear to new events only");

    irq_release_a: assert property (@(posedge clock) disable iff (!resetn)
        rd_status && !irq_event |=> !irq_drive)
        else $error("interrupt output stayed on after status read");

    irq_cause_a: assert property (@(posedge clock) disable iff (!resetn)
        $rose(irq_drive) |-> $past(command_reg[rtc_pkg::BIT_GLOBAL_EN])
            && $past(|mask_reg))
        else $error("interrupt raised while not enabled");

    alarm_flags_a: assert property (@(posedge clock) disable iff (!resetn)
        alarm_fire |=> status_reg[rtc_pkg::BIT_ALARM] && status_reg[rtc_pkg::BIT_ANY]
            && irq_drive)
        else $error("alarm match did not flag and drive interrupt");

    count_flags_a: assert property (@(posedge clock) disable iff (!resetn)
        |counter_increment
            |=> (status_reg[6:1] & $past(counter_increment)) == $past(counter_increment))
        else $error("counter increment not flagged");

    io_block_a: assert property (@(posedge clock) disable iff (!resetn)
        !supply_valid_signal |=> !data_oe && !counter_wr.en)
        else $error("bus active while backup supply is low");

    mask_write_a: assert property (@(posedge clock) disable iff (!resetn)
        wr_start && bus_pins.addr == rtc_pkg::ADDR_STATUS
            |=> mask_reg == $past(bus_pins.wdata[6:0]))
        else $error("mask write not taken");

    alarm_once_a: assert property (@(posedge clock) disable iff (!resetn)
        alarm_hit |=> !alarm_hit)
        else $error("alarm compared twice for one tick");
endmodule

// [rtc_pkg.sv]
// Shared constants and carrier types for the clock's bus, latch and interrupt logic
package rtc_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int TIME_WORDS = 8;
    localparam int ALARM_WORDS = 8;
    localparam int PERIODIC_COUNT = 6;
    // Register map
    localparam logic [4:0] ADDR_HUND = 5'h00;
    localparam logic [4:0] ADDR_TIME_LAST = 5'h07;
    localparam logic [4:0] ADDR_ALARM_FIRST = 5'h08;
    localparam logic [4:0] ADDR_ALARM_LAST = 5'h0F;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    localparam logic [4:0] ADDR_COMMAND = 5'h11;
    // Field positions
    localparam int BIT_ALARM = 0;
    localparam int BIT_ANY = 7;
    localparam int BIT_GLOBAL_EN = 4;
    localparam int BIT_PERIODIC_LO = 1;
    localparam int BIT_PERIODIC_HI = 6;
    localparam int BIT_ALARM_FIELD_MASK = 7;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [6:0] MASK_RESET = 7'h00;
    localparam logic [7:0] COMMAND_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Parallel bus pins as seen at the chip, strobes active low
    typedef struct packed {
        logic chip_sel_n;
        logic read_n;
        logic write_n;
        logic [4:0] addr;
        logic [7:0] wdata;
    } bus_pins_t;

    // Write toward the counter chain
    typedef struct packed {
        logic en;
        logic [2:0] index;
        logic [7:0] data;
    } counter_wr_t;

    // Eight time bytes in register order, index 0 is hundredths
    typedef logic [7:0][7:0] time_bank_t;
endpackage

// [alarm_store.sv]
// Alarm storage RAM with a registered read port and all words visible to the comparator
`timescale 1ns/1ps
module alarm_store #(
    parameter int WORDS = 8,
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [$clog2(WORDS)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(WORDS)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    output logic [WORDS-1:0][WIDTH-1:0] contents
);
    logic [WORDS-1:0][WIDTH-1:0] mem_reg;
    logic [WORDS-1:0][WIDTH-1:0] mem_next;
    logic [WIDTH-1:0] rd_reg;

    // Word update on write
    always_comb begin
        mem_next = mem_reg;
        if (wr_en) begin
            mem_next[wr_addr] = wr_data;
        end
    end

    // Storage and read register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mem_reg <= '0;
            rd_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            rd_reg <= mem_reg[rd_addr];
        end
    end

    assign rd_data = rd_reg;
    assign contents = mem_reg;
endmodule

// [host_bus_model.sv]
// Host processor model driving the parallel register bus of the clock
`timescale 1ns/1ps
module host_bus_model (
    input wire logic clock,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output rtc_pkg::bus_pins_t bus_pins
);
    // Bus idle with all strobes high
    initial begin
        bus_pins = '{1'b1, 1'b1, 1'b1, 5'h00, 8'h00};
    end

    // One strobed access held over two edges, then released for a cycle
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe);
        @(posedge clock);
        #1;
        bus_pins = '{1'b0, wr, !wr, a, d};
        @(posedge clock);
        @(posedge clock);
        q = data_out;
        oe = data_oe;
        #1;
        // Released lines must not keep showing their last value
        bus_pins = '{1'b1, 1'b1, 1'b1, ~a, ~d};
    endtask

    task automatic set_mask(input logic [7:0] m);
        logic [7:0] q;
        logic oe;
        access(1'b1, rtc_pkg::ADDR_STATUS, m, q, oe);
    endtask

    task automatic service(output logic [7:0] q);
        logic oe;
        access(1'b0, rtc_pkg::ADDR_STATUS, 8'h00, q, oe);
    endtask

    task automatic snapshot(output rtc_pkg::time_bank_t s);
        logic oe;
        for (int i = 0; i < 8; i++) begin
            access(1'b0, 5'(i), 8'h00, s[i], oe);
        end
    endtask
endmodule

// [testbench.sv]
// Self-checking bench for the time latch, status and interrupt logic
`timescale 1ns/1ps
module testbench;
    logic clock;
    logic resetn;
    logic supply_valid_signal;
    rtc_pkg::time_bank_t time_live;
    logic [5:0] counter_increment;
    rtc_pkg::bus_pins_t bus_pins;
    logic [7:0] data_out;
    logic data_oe;
    logic irq_drive;
    rtc_pkg::counter_wr_t counter_wr;
    logic [7:0] command_out;
    int err_count;
    int samples_checked;
    int cycles;
    logic [7:0] q;
    logic oe;
    rtc_pkg::time_bank_t snap;
    int cwr_count;
    rtc_pkg::counter_wr_t cwr_seen;

    rtc_latch_irq u_dut (.clock(clock), .resetn(resetn), .bus_pins(bus_pins),
        .supply_valid_signal(supply_valid_signal), .time_live(time_live),
        .counter_increment(counter_increment), .data_out(data_out), .data_oe(data_oe),
        .irq_drive(irq_drive), .counter_wr(counter_wr), .command_out(command_out));
    host_bus_model u_host (.clock(clock), .data_out(data_out), .data_oe(data_oe),
        .bus_pins(bus_pins));

    // Clock at 250 MHz
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Counts counter chain write pulses and keeps the last one
    always @(posedge clock) begin
        if (counter_wr.en === 1'b1) begin
            cwr_count++;
            cwr_seen = counter_wr;
        end
    end

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One-cycle increment pulse, then time for status and output to settle
    task automatic pulse(input int k);
        @(posedge clock);
        #1;
        counter_increment = 6'(1 << k);
        @(posedge clock);
        #1;
        counter_increment = 6'h00;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic [4:0] a);
        u_host.access(1'b0, a, 8'h00, q, oe);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d, q, oe);
    endtask

    // Latch frozen by hundredths read, hundredths always live
    task automatic t_latch();
        for (int i = 0; i < 8; i++) time_live[i] = 8'(8'h10 + i);
        rd(5'h00);
        check8("hundredths", 8'h10, q);
        check1("read oe", 1'b1, oe);
        for (int i = 0; i < 8; i++) time_live[i] = 8'(8'h20 + i);
        for (int i = 1; i < 8; i++) begin
            rd(5'(i));
            check8("latched time", 8'(8'h10 + i), q);
        end
        u_host.snapshot(snap);
        for (int i = 0; i < 8; i++) check8("snapshot", 8'(8'h20 + i), snap[i]);
    endtask

    // Every periodic source flagged, only the masked-in one interrupts
    task automatic t_periodic();
        wr(rtc_pkg::ADDR_COMMAND, 8'h10);
        rd(rtc_pkg::ADDR_COMMAND);
        check8("command read", 8'h10, q);
        check8("command out", 8'h10, command_out);
        u_host.set_mask(8'h08);
        u_host.service(q);
        for (int k = 0; k < 6; k++) begin
            pulse(k);
            check1("irq periodic", k == 2, irq_drive);
            u_host.service(q);
            check8("status periodic", 8'((1 << (k + 1)) | ((k == 2) ? 8'h80 : 8'h00)), q);
            check1("irq released", 1'b0, irq_drive);
            u_host.service(q);
            check8("status cleared", 8'h00, q);
        end
        pulse(2);
        u_host.service(q);
        pulse(2);
        check1("irq repeat", 1'b1, irq_drive);
        u_host.service(q);
        check8("status repeat", 8'h88, q);
        wr(rtc_pkg::ADDR_COMMAND, 8'h00);
        u_host.set_mask(8'h7E);
        pulse(4);
        check1("irq no global", 1'b0, irq_drive);
        u_host.service(q);
        check8("status no global", 8'h20, q);
    endtask

    // Alarm match with masked hundredths and weekday fields
    task automatic t_alarm();
        wr(rtc_pkg::ADDR_COMMAND, 8'h10);
        u_host.set_mask(8'h01);
        wr(5'h08, 8'h80);
        for (int i = 1; i < 7; i++) wr(5'(8 + i), 8'(8'h30 + i));
        wr(5'h0F, 8'h80);
        rd(5'h09);
        check8("alarm ram", 8'h31, q);
        rd(5'h0F);
        check8("alarm ram mask", 8'h80, q);
        time_live[0] = 8'h00;
        for (int i = 1; i < 7; i++) time_live[i] = 8'(8'h30 + i);
        time_live[7] = 8'h5A;
        u_host.service(q);
        pulse(0);
        check1("irq alarm", 1'b1, irq_drive);
        u_host.service(q);
        check8("status alarm", 8'h83, q);
        time_live[0] = 8'h05;
        pulse(0);
        check1("irq hund nonzero", 1'b0, irq_drive);
        u_host.service(q);
        check8("status hund nonzero", 8'h02, q);
        time_live[0] = 8'h00;
        u_host.set_mask(8'h00);
        pulse(0);
        check1("irq alarm masked", 1'b0, irq_drive);
        u_host.service(q);
        check8("status alarm masked", 8'h02, q);
    endtask

    // Low backup supply blocks the bus, coincident event survives a clear
    task automatic t_supply_and_race();
        wr(5'h03, 8'h45);
        check8("counter write data", 8'h45, cwr_seen.data);
        check8("counter write index", 8'h03, {5'h00, cwr_seen.index});
        check8("counter write pulses", 8'h01, 8'(cwr_count));
        pulse(3);
        supply_valid_signal = 1'b0;
        rd(rtc_pkg::ADDR_STATUS);
        check1("oe while blocked", 1'b0, oe);
        wr(rtc_pkg::ADDR_COMMAND, 8'h00);
        wr(5'h02, 8'h77);
        supply_valid_signal = 1'b1;
        check8("counter write blocked", 8'h01, 8'(cwr_count));
        rd(rtc_pkg::ADDR_COMMAND);
        check8("command kept", 8'h10, q);
        u_host.service(q);
        check8("status kept", 8'h10, q);
        rd(5'h12);
        check8("unmapped read", 8'h00, q);
        fork
            u_host.service(q);
            pulse(1);
        join
        check8("status at race", 8'h00, q);
        u_host.service(q);
        check8("status after race", 8'h04, q);
    endtask

    initial begin
        resetn = 1'b0;
        supply_valid_signal = 1'b1;
        time_live = '0;
        counter_increment = 6'h00;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        cwr_count = 0;
        repeat (12) @(posedge clock);
        #1;
        resetn = 1'b1;
        @(posedge clock);
        #1;
        t_latch();
        t_periodic();
        t_alarm();
        t_supply_and_race();
        give_verdict();
    end
endmodule
